// [interrupt_priority_regs_3_to_7_test.sv]
// Purpose: self-checking bench for the priority register block
// Assumes: apb slave, levels move at the acked access edge
// Notes:   index 5 is an unmapped word, writes there are dropped
`timescale 1ns/10ps
module interrupt_priority_regs_3_to_7_test
  import ipr_pkg::*;
;
  // ****************************************************************
  // signals and model
  // ****************************************************************
  logic        core_clk_i, pready, pslverr;
  logic        rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [53:0] lv;
  logic [15:0] m [5];
  logic [15:0] mk [5] = '{IPR_MASK_GRP3, IPR_MASK_GRP4, IPR_MASK_STD,
                          IPR_MASK_STD, IPR_MASK_STD};
  logic [11:0] ofs [6] = '{IPR_OFS_GRP3, IPR_OFS_GRP4, IPR_OFS_GRP5,
                           IPR_OFS_GRP6, IPR_OFS_GRP7, 12'h014};
  int          n_mismatch = 0, checks_done = 0, i, r;

  ipr_regs dut_u (.core_clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr,
    .dma_ch1_done_level(lv[53:51]), .adc_one_done_level(lv[50:48]),
    .uart_one_tx_level(lv[47:45]), .pin_change_level(lv[44:42]),
    .i2c_one_master_level(lv[41:39]), .i2c_one_slave_level(lv[38:36]),
    .capture_eight_level(lv[35:33]), .capture_seven_level(lv[32:30]),
    .adc_two_done_level(lv[29:27]), .ext_irq_one_level(lv[26:24]),
    .timer_four_level(lv[23:21]), .compare_four_level(lv[20:18]),
    .compare_three_level(lv[17:15]), .dma_ch2_done_level(lv[14:12]),
    .uart_two_tx_level(lv[11:9]), .uart_two_rx_level(lv[8:6]),
    .ext_irq_two_level(lv[5:3]), .timer_five_level(lv[2:0]));

  // 50 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [53:0] e, input logic [53:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  // fields packed high to low, register by register, spare slots skipped
  function logic [53:0] exp_lv;
    exp_lv = '0;
    for (int k = 0; k < 5; k++)
      for (int b = 12; b >= 0; b -= 4)
        if (mk[k][b]) exp_lv = {exp_lv[50:0], m[k][b +: 3]};
  endfunction

  // one apb transfer; the pready wait is bounded to catch a hang
  task apb(input bit w, input int x, input logic [31:0] d);
    int n;
    logic se;
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ofs[x];
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      stop_test();
    end
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && x < 5) m[x] = d[15:0] & mk[x];
    // levels update at the access edge, so look one edge later
    @(posedge core_clk_i);
    chk("levels", exp_lv(), lv);
    chk("slverr", 54'h0, {53'h0, se});
    if (!w) chk("rdata", {22'h0, x < 5 ? m[x] : 16'h0}, {22'h0, q});
  endtask

  task do_reset;
    rst_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 5; i++) m[i] = mk[i] & 16'h4444;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(72174));
    do_reset();
    for (r = 0; r < 6; r++) apb(1'b0, r, 32'h0);
    $display("test reset done");
    for (i = 0; i < 8; i++)
      for (r = 0; r < 12; r++) apb(~r[0], r / 2, 32'hFFFF0000 | i * 'h1111);
    $display("test codes done");
    for (i = 0; i < 60; i++) apb($urandom % 2, $urandom % 6, $urandom);
    $display("test random done");
    do_reset();
    for (r = 0; r < 6; r++) apb(1'b0, r, 32'h0);
    $display("test second reset done");
    stop_test();
  end
endmodule

// [ipr_field.sv]
// Purpose: one 3-bit priority level field
// Assumes: single clock, synchronous active-low reset
// Notes:   unimplemented fields tie to zero and ignore writes
`timescale 1ns/10ps
module ipr_field
  import ipr_pkg::*;
#(
  parameter bit IMPL = 1'b1
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // write port
  input  wire logic             wr_i,
  input  wire logic [2:0]       wdata_i,
  // level out
  output logic      [2:0]       level_o
);

  // ****************************************************************
  // storage
  // ****************************************************************
  if (IMPL) begin : g_impl
    logic [2:0] lvl_q;
    // level held until rewritten or reset
    always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
        lvl_q <= IPR_LVL_RST;
      end else if (wr_i) begin
        lvl_q <= wdata_i;
      end
    end
    assign level_o = lvl_q;
  end else begin : g_none
    assign level_o = IPR_LVL_OFF;
  end

endmodule

// [ipr_pkg.sv]
// Purpose: constants shared by the priority register block
// Assumes: 32-bit APB data, registers in the low 16 bits
// Notes:   offsets chosen for this block, one aligned word each
package ipr_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          IPR_NUM_REGS   = 5;
  localparam int          IPR_NUM_SRC    = 19;
  localparam int          IPR_LVL_W      = 3;
  localparam int          IPR_ADDR_W     = 12;
  localparam logic [11:0] IPR_OFS_GRP3   = 12'h000;
  localparam logic [11:0] IPR_OFS_GRP4   = 12'h004;
  localparam logic [11:0] IPR_OFS_GRP5   = 12'h008;
  localparam logic [11:0] IPR_OFS_GRP6   = 12'h00C;
  localparam logic [11:0] IPR_OFS_GRP7   = 12'h010;

  // ****************************************************************
  // field layout and reset
  // ****************************************************************
  localparam int          IPR_FLD_HI     = 12;
  localparam int          IPR_FLD_MH     = 8;
  localparam int          IPR_FLD_ML     = 4;
  localparam int          IPR_FLD_LO     = 0;
  localparam logic [2:0]  IPR_LVL_RST    = 3'h4;
  localparam logic [2:0]  IPR_LVL_OFF    = 3'h0;
  // implemented-bit masks per register
  localparam logic [15:0] IPR_MASK_GRP3  = 16'h0777;
  localparam logic [15:0] IPR_MASK_GRP4  = 16'h7077;
  localparam logic [15:0] IPR_MASK_STD   = 16'h7777;
  localparam logic [15:0] IPR_RST_GRP3   = 16'h0444;
  localparam logic [15:0] IPR_RST_GRP4   = 16'h4044;
  localparam logic [15:0] IPR_RST_STD    = 16'h4444;

endpackage

// [ipr_regs.sv]
// Purpose: APB slave holding interrupt priority groups three to seven
// Assumes: 20 MHz core_clk_i, APB3 master, one word per register
// Notes:   one access cycle; unmapped reads return zero, slverr low
`timescale 1ns/10ps
module ipr_regs
  import ipr_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [IPR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // levels to arbitration, 000 means disabled
  output logic      [2:0]            dma_ch1_done_level,
  output logic      [2:0]            adc_one_done_level,
  output logic      [2:0]            uart_one_tx_level,
  output logic      [2:0]            pin_change_level,
  output logic      [2:0]            i2c_one_master_level,
  output logic      [2:0]            i2c_one_slave_level,
  output logic      [2:0]            capture_eight_level,
  output logic      [2:0]            capture_seven_level,
  output logic      [2:0]            adc_two_done_level,
  output logic      [2:0]            ext_irq_one_level,
  output logic      [2:0]            timer_four_level,
  output logic      [2:0]            compare_four_level,
  output logic      [2:0]            compare_three_level,
  output logic      [2:0]            dma_ch2_done_level,
  output logic      [2:0]            uart_two_tx_level,
  output logic      [2:0]            uart_two_rx_level,
  output logic      [2:0]            ext_irq_two_level,
  output logic      [2:0]            timer_five_level
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  localparam int         NUM_R = IPR_NUM_REGS;
  logic                  setup_phase;
  logic                  wr_acc;
  logic [NUM_R-1:0]      sel;
  logic [15:0]           grp   [NUM_R];
  logic [15:0]           rd_mux;
  logic                  hit;

  // read is fetched in setup; a write lands only at the acked access edge
  assign setup_phase = psel & ~penable;
  assign wr_acc      = psel & penable & pready & pwrite;

  // one-hot register select from the word address
  always_comb begin
    sel = '0;
    hit = 1'b1;
    case (paddr)
      IPR_OFS_GRP3: sel = 5'h01;
      IPR_OFS_GRP4: sel = 5'h02;
      IPR_OFS_GRP5: sel = 5'h04;
      IPR_OFS_GRP6: sel = 5'h08;
      IPR_OFS_GRP7: sel = 5'h10;
      default:      hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // field storage, four slots per register
  // ****************************************************************
  // slot positions; masks decide which slots exist
  localparam int SLOT_LSB [4] = '{IPR_FLD_LO, IPR_FLD_ML,
                                  IPR_FLD_MH, IPR_FLD_HI};
  localparam logic [15:0] MASKS [NUM_R] = '{IPR_MASK_GRP3,
                                          IPR_MASK_GRP4,
                                          IPR_MASK_STD,
                                          IPR_MASK_STD,
                                          IPR_MASK_STD};

  genvar r, s;
  generate
    for (r = 0; r < NUM_R; r++) begin : g_reg
      logic [2:0] lvl [4];
      for (s = 0; s < 4; s++) begin : g_slot
        // absent slots keep reading zero, ..layout
        ipr_field #(
          .IMPL (MASKS[r][SLOT_LSB[s]])
        ) u_fld (
          .core_clk_i (core_clk_i),
          .rst_n_i    (rst_n_i),
          .wr_i       (wr_acc & sel[r]),
          .wdata_i    (pwdata[SLOT_LSB[s] +: 3]),
          .level_o    (lvl[s])
        );
      end
      // separator bits and bit 15 stay zero
      assign grp[r] = {1'b0, lvl[3], 1'b0, lvl[2],
                       1'b0, lvl[1], 1'b0, lvl[0]};
    end
  endgenerate

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < NUM_R; i++) begin
      if (sel[i]) begin
        rd_mux = grp[i];
      end
    end
  end

  // read data registered in setup, valid during the access phase
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= (hit && !pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  // single-cycle access phase; pready high only for that cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // no error answer: unmapped reads are zero, writes dropped
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // level outputs to arbitration
  // ****************************************************************
  // driven straight from field flops; 111 top, 001 low, 000 off
  assign dma_ch1_done_level   = g_reg[0].lvl[2];
  assign adc_one_done_level   = g_reg[0].lvl[1];
  assign uart_one_tx_level    = g_reg[0].lvl[0];
  assign pin_change_level     = g_reg[1].lvl[3];
  assign i2c_one_master_level = g_reg[1].lvl[1];
  assign i2c_one_slave_level  = g_reg[1].lvl[0];
  assign capture_eight_level  = g_reg[2].lvl[3];
  assign capture_seven_level  = g_reg[2].lvl[2];
  assign adc_two_done_level   = g_reg[2].lvl[1];
  assign ext_irq_one_level    = g_reg[2].lvl[0];
  assign timer_four_level     = g_reg[3].lvl[3];
  assign compare_four_level   = g_reg[3].lvl[2];
  assign compare_three_level  = g_reg[3].lvl[1];
  assign dma_ch2_done_level   = g_reg[3].lvl[0];
  assign uart_two_tx_level    = g_reg[4].lvl[3];
  assign uart_two_rx_level    = g_reg[4].lvl[2];
  assign ext_irq_two_level    = g_reg[4].lvl[1];
  assign timer_five_level     = g_reg[4].lvl[0];

endmodule

// [ipr_regs_sva.sv]
// Purpose: port checks for the priority register block
// Assumes: one access cycle apb slave, writes land at the access edge
// Notes:   bound to ipr_regs at the foot of this file
`timescale 1ns/10ps
module ipr_regs_sva
  import ipr_pkg::*;
(
  // clock, reset and apb
  input wire logic              core_clk_i,
  input wire logic              rst_n_i,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // watched levels
  input wire logic [2:0]        dma_ch1_done_level,
  input wire logic [2:0]        pin_change_level,
  input wire logic [2:0]        uart_two_tx_level
);
  // ****************************************************************
  // helpers and properties
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] wd_q;
  wire         setup_w = psel && !penable;
  wire         rd_w = psel && penable && pready && !pwrite;
  wire         acc_w = psel && penable && pready;
  // write data of the access cycle, for the level checks
  always_ff @(posedge core_clk_i) begin
    wd_q <= pwdata;
  end
  property p_rdy; setup_w |=> pready && !pslverr; endproperty
  a_rdy: assert property (p_rdy) else $error("answer late");
  property p_hi; pready |-> prdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper half set");
  property p_g3; rd_w && paddr == IPR_OFS_GRP3 |->
    (prdata[15:0] & ~IPR_MASK_GRP3) == 16'h0000; endproperty
  a_g3: assert property (p_g3) else $error("group3 spare bit");
  property p_g4; rd_w && paddr == IPR_OFS_GRP4 |-> prdata[11:7] == 5'h00;
  endproperty
  a_g4: assert property (p_g4) else $error("group4 spare bit");
  property p_w3; acc_w && pwrite && paddr == IPR_OFS_GRP3 |=>
    dma_ch1_done_level == wd_q[10:8]; endproperty
  a_w3: assert property (p_w3) else $error("dma1 level");
  property p_w4; acc_w && pwrite && paddr == IPR_OFS_GRP4 |=>
    pin_change_level == wd_q[14:12]; endproperty
  a_w4: assert property (p_w4) else $error("pin change level");
  property p_w7; acc_w && pwrite && paddr == IPR_OFS_GRP7 |=>
    uart_two_tx_level == wd_q[14:12]; endproperty
  a_w7: assert property (p_w7) else $error("uart2 tx level");
  property p_rb; rd_w && paddr == IPR_OFS_GRP7 |->
    prdata[14:12] == uart_two_tx_level; endproperty
  a_rb: assert property (p_rb) else $error("readback");
  property p_hold; !(acc_w && pwrite) |=> $stable(dma_ch1_done_level);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved");
  c_wr: cover property (acc_w && pwrite);
  c_rd: cover property (rd_w);
  c_g4: cover property (rd_w && paddr == IPR_OFS_GRP4);
endmodule
bind ipr_regs ipr_regs_sva u_sva (.core_clk_i, .rst_n_i, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .dma_ch1_done_level, .pin_change_level, .uart_two_tx_level);
